// [hw/usb_otg_reset_and_interrupts.v]
// reset sequencing, link clock gating and interrupt merging of the otg core
//
// Behaviour
// - software bit gates the link reference clock
// - stop line held asserted during reset
// - hardware reset clears interfaces, registers, state
// - reset synchronised into bus and link domains
// - core soft reset bit resets from software
// - one interrupt output for all conditions
// - host wakeup, session, disconnect, channel, port events
// - periodic tx empty, optionally half empty
// - device resume, reset, suspend, frame, enumeration
// - device fetch suspended on full fifo
// - device endpoint pending at microframe end
// - device isochronous out packet dropped event
// - common id, nptx empty, rx, sof events
// - mode mismatch on wrong-mode register access
// - otg debounce, timeout, hnp, srp, session end
// - link clock 60 MHz, bus 60-200 MHz
//
// The AHB-Lite slave port and the register offsets were chosen for this implementation.
`default_nettype none
`include "usb_otg_rst_irq_map.vh"

module usb_otg_reset_and_interrupts #(
	// nominal link reference rate; the logic only counts its edges
	parameter integer LINK_MHZ = `LINK_CLK_MHZ
) (
	input wire mclk,
	input wire rst,
	input wire hsel,
	input wire [7:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output reg [31:0] hrdata,
	input wire link_clk,
	input wire host_mode,
	input wire [`NUM_EV-1:0] events,
	input wire ptx_half_empty,
	output reg link_clk_enable,
	output reg phy_stop,
	output reg bus_core_reset,
	output reg link_core_reset,
	output reg irq
);

	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_HOLD = 3'b010;
	localparam [2:0] ST_DRAIN = 3'b100;

	// one-hot register select, shared by read and write decode
	function [`NUM_REGS-1:0] reg_sel;
		input [7:0] a;
		begin
			reg_sel = {`NUM_REGS{1'b0}};
			case (a)
				`OFF_CLK_CTRL: reg_sel[`SEL_CLK] = 1'b1;
				`OFF_RST_CTRL: reg_sel[`SEL_RST] = 1'b1;
				`OFF_INT_STATUS: reg_sel[`SEL_STAT] = 1'b1;
				`OFF_INT_MASK: reg_sel[`SEL_MASK] = 1'b1;
				`OFF_MODE: reg_sel[`SEL_MODE] = 1'b1;
				`OFF_HOST_CFG: reg_sel[`SEL_HOST] = 1'b1;
				default: reg_sel = {`NUM_REGS{1'b0}};
			endcase
		end
	endfunction

	// conditions allowed in the current operating mode
	function [`NUM_EV-1:0] mode_allowed;
		input host;
		begin
			if (host) begin
				mode_allowed = ~`DEV_ONLY;
			end else begin
				mode_allowed = ~`HOST_ONLY;
			end
		end
	endfunction

	// bus-side reset: the input is stretched through two stages
	// so that short reset pulses still reach every bus-side register
	reg [1:0] rst_pipe;
	wire hw_rst;
	assign hw_rst = rst | rst_pipe[1];

	always @(posedge mclk) begin
		if (rst) begin
			rst_pipe <= 2'b11;
		end else begin
			rst_pipe <= {rst_pipe[0], 1'b0};
		end
	end

	// link clock sampled on mclk; a level counts once stages 2 and 3 agree
	// each link level must last two mclk periods or its edge is lost
	reg lk_s1;
	reg lk_s2;
	reg lk_s3;
	reg lk_level;
	reg lk_level_q;
	wire lk_agree;
	wire link_edge;

	assign lk_agree = lk_s2 == lk_s3;
	// a gated clock simply never produces an edge here
	assign link_edge = lk_level & ~lk_level_q & link_clk_enable;

	always @(posedge mclk) begin
		if (rst) begin
			lk_s1 <= 1'b0;
			lk_s2 <= 1'b0;
			lk_s3 <= 1'b0;
			lk_level <= 1'b0;
			lk_level_q <= 1'b0;
		end else begin
			lk_s1 <= link_clk;
			lk_s2 <= lk_s1;
			lk_s3 <= lk_s2;
			if (lk_agree) begin
				lk_level <= lk_s3;
			end
			lk_level_q <= lk_level;
		end
	end

	// soft reset sequencer
	// with the link clock gated the sequence stalls in hold until software
	// enables the clock again or a hardware reset, so software enables it before starting
	reg [2:0] state;
	reg [2:0] next_state;
	reg [`CNT_W-1:0] bus_cnt;
	reg [`CNT_W-1:0] link_cnt;
	reg link_req_s1;
	reg link_rst;
	wire soft_hold;
	wire link_req;
	wire soft_start;
	wire bus_rst;

	assign soft_hold = state == ST_HOLD;
	assign link_req = hw_rst | soft_hold;
	assign bus_rst = hw_rst | soft_hold;

	// bus slave
	// write data follows its address by a cycle, so the address is kept
	reg wr_pend;
	reg [7:0] wr_addr;
	wire acc;
	wire [`NUM_REGS-1:0] a_sel;
	wire [`NUM_REGS-1:0] w_sel;
	wire wr_word;

	assign acc = hsel & htrans[1] & hready & (hsize == `HSIZE_WORD);
	assign a_sel = reg_sel(haddr);
	assign w_sel = wr_pend ? reg_sel(wr_addr) : {`NUM_REGS{1'b0}};
	assign wr_word = wr_pend;
	// zero wait states: every word answers in its data phase
	assign hreadyout = 1'b1;
	assign hresp = `HRESP_OKAY;
	assign soft_start = w_sel[`SEL_RST] & hwdata[`BIT_SOFT_RST];

	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (soft_start) begin
					next_state = ST_HOLD;
				end
			end
			ST_HOLD: begin
				// hold long enough for both domains to see the reset
				if (bus_cnt >= `BUS_MIN_RST &&
				    link_cnt >= `LINK_MIN_EDGES) begin
					next_state = ST_DRAIN;
				end
			end
			ST_DRAIN: begin
				// busy stays set until the link side has left reset too
				if (!link_req_s1 && !link_rst) begin
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always @(posedge mclk) begin
		if (hw_rst) begin
			state <= ST_IDLE;
			bus_cnt <= {`CNT_W{1'b0}};
		end else begin
			state <= next_state;
			if (!soft_hold) begin
				bus_cnt <= {`CNT_W{1'b0}};
			end else if (bus_cnt != {`CNT_W{1'b1}}) begin
				bus_cnt <= bus_cnt + 1'b1;
			end
		end
	end

	// link-side reset, advanced only on link clock edges
	always @(posedge mclk) begin
		if (rst) begin
			link_req_s1 <= 1'b1;
			link_rst <= 1'b1;
			link_cnt <= {`CNT_W{1'b0}};
		end else if (link_edge) begin
			link_req_s1 <= link_req;
			link_rst <= link_req_s1;
			if (!link_req) begin
				link_cnt <= {`CNT_W{1'b0}};
			end else if (link_cnt != {`CNT_W{1'b1}}) begin
				link_cnt <= link_cnt + 1'b1;
			end
		end
	end

	// without the stop line the phy never starts its clock
	// registered so the pin never glitches while the two resets overlap
	always @(posedge mclk) begin
		if (rst) begin
			phy_stop <= 1'b1;
			bus_core_reset <= 1'b1;
			link_core_reset <= 1'b1;
		end else begin
			phy_stop <= bus_rst | link_rst;
			bus_core_reset <= bus_rst;
			link_core_reset <= link_rst;
		end
	end

	// control and status registers
	reg ptx_half;
	reg [`NUM_EV-1:0] int_mask;
	reg [`NUM_EV-1:0] int_status;
	reg mismatch;
	wire [`NUM_EV-1:0] raw_ev;
	wire [`NUM_EV-1:0] set_ev;
	wire [`NUM_EV-1:0] clr_ev;
	wire host_acc_wrong;

	// only the host config word belongs to one mode; none is device-only
	// host config accessed while running as device
	assign host_acc_wrong = acc & a_sel[`SEL_HOST] & ~host_mode;

	genvar gi;
	generate
		for (gi = 0; gi < `NUM_EV; gi = gi + 1) begin : g_raw
			if (gi == `EV_PTX_EMPTY) begin : g_ptx
				assign raw_ev[gi] = ptx_half ? ptx_half_empty :
				    events[gi];
			end else if (gi == `EV_MODE_MISMATCH) begin : g_mm
				assign raw_ev[gi] = events[gi] | mismatch;
			end else begin : g_plain
				assign raw_ev[gi] = events[gi];
			end
		end
	endgenerate

	assign set_ev = raw_ev & mode_allowed(host_mode);
	assign clr_ev = w_sel[`SEL_STAT] ? hwdata[`NUM_EV-1:0] :
	    {`NUM_EV{1'b0}};

	always @(posedge mclk) begin
		if (hw_rst) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			link_clk_enable <= `CLK_EN_RST;
			ptx_half <= `PTX_HALF_RST;
			int_mask <= `MASK_RST;
			mismatch <= 1'b0;
		end else begin
			wr_pend <= acc & hwrite;
			wr_addr <= haddr;
			mismatch <= host_acc_wrong;
			if (w_sel[`SEL_CLK]) begin
				link_clk_enable <= hwdata[`BIT_CLK_EN];
			end
			if (w_sel[`SEL_HOST] & host_mode) begin
				ptx_half <= hwdata[`BIT_PTX_HALF];
			end
			if (w_sel[`SEL_MASK]) begin
				int_mask <= hwdata[`NUM_EV-1:0];
			end
		end
	end

	// pending state is core state, so a soft reset clears it as well
	// events arriving during a soft reset are dropped, not queued
	always @(posedge mclk) begin
		if (bus_rst) begin
			int_status <= `STAT_RST;
			irq <= 1'b0;
		end else begin
			// a new event beats a clear landing in the same cycle
			int_status <= (int_status & ~clr_ev) | set_ev;
			irq <= |(int_status & int_mask);
		end
	end

	// read data registered in the address phase, valid in the data phase
	// unmapped words read as zero rather than leaving stale data on the bus
	always @(posedge mclk) begin
		if (hw_rst) begin
			hrdata <= 32'h00000000;
		end else if (acc & ~hwrite) begin
			hrdata <= 32'h00000000;
			if (a_sel[`SEL_CLK]) begin
				hrdata[`BIT_CLK_EN] <= link_clk_enable;
			end
			if (a_sel[`SEL_RST]) begin
				hrdata[`BIT_SOFT_RST] <= ~state[0];
				hrdata[`BIT_LINK_RST] <= link_rst;
				hrdata[`BIT_BUS_RST] <= bus_rst;
			end
			if (a_sel[`SEL_STAT]) begin
				hrdata[`NUM_EV-1:0] <= int_status;
			end
			if (a_sel[`SEL_MASK]) begin
				hrdata[`NUM_EV-1:0] <= int_mask;
			end
			if (a_sel[`SEL_MODE]) begin
				hrdata[`BIT_HOST_MODE] <= host_mode;
				hrdata[`BIT_IRQ] <= irq;
			end
			if (a_sel[`SEL_HOST]) begin
				hrdata[`BIT_PTX_HALF] <= ptx_half;
			end
		end
	end

endmodule // usb_otg_reset_and_interrupts
`default_nettype wire

// [hw/usb_otg_rst_irq_map.vh]
// register map, field positions and counts of the reset and interrupt block
`ifndef USB_OTG_RST_IRQ_MAP_VH
`define USB_OTG_RST_IRQ_MAP_VH

`define OFF_CLK_CTRL 8'h00
`define OFF_RST_CTRL 8'h04
`define OFF_INT_STATUS 8'h08
`define OFF_INT_MASK 8'h0C
`define OFF_MODE 8'h10
`define OFF_HOST_CFG 8'h14

`define NUM_REGS 6
`define SEL_CLK 0
`define SEL_RST 1
`define SEL_STAT 2
`define SEL_MASK 3
`define SEL_MODE 4
`define SEL_HOST 5

`define BIT_CLK_EN 0
`define BIT_SOFT_RST 0
`define BIT_LINK_RST 1
`define BIT_BUS_RST 2
`define BIT_HOST_MODE 0
`define BIT_IRQ 1
`define BIT_PTX_HALF 0

`define NUM_EV 27
`define EV_PTX_EMPTY 3
`define EV_MODE_MISMATCH 18
`define HOST_ONLY 27'h040007F
`define DEV_ONLY 27'h401FF80

`define CLK_EN_RST 1'h1
`define PTX_HALF_RST 1'h0
`define MASK_RST 27'h0000000
`define STAT_RST 27'h0000000

`define CNT_W 4
`define LINK_MIN_EDGES 4'hC
`define BUS_MIN_RST 4'h2
`define LINK_CLK_MHZ 60
`define BUS_CLK_MIN_MHZ 60
`define BUS_CLK_MAX_MHZ 200

`define HSIZE_WORD 3'h2
`define HRESP_OKAY 1'h0

`endif

// [bench/otg_props.sv]
// concurrent checks on the reset and interrupt block ports
`default_nettype none
module otg_props (
	input wire logic mclk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic link_clk_enable,
	input wire logic phy_stop,
	input wire logic bus_core_reset,
	input wire logic link_core_reset,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	logic wr_rst = 1'b0;
	// data phase of a write to the reset control word
	always @(posedge mclk) begin
		wr_rst <= hsel && htrans[1] && hwrite && haddr == 8'h04;
	end
	a_stop_set: assert property (
		(bus_core_reset || link_core_reset) |-> phy_stop)
		else $error("stop low in reset");
	a_stop_clear: assert property (
		!bus_core_reset && !link_core_reset |-> !phy_stop)
		else $error("stop high out of reset");
	a_link_last: assert property (
		$fell(bus_core_reset) |-> link_core_reset)
		else $error("link reset left before bus");
	a_bus_release: assert property (
		$fell(bus_core_reset) |-> !$past(rst) && !$past(rst, 2))
		else $error("bus reset left too early");
	a_rst_hold: assert property (
		$fell(rst) |-> bus_core_reset [*2])
		else $error("bus reset not stretched");
	a_irq_cleared: assert property (
		bus_core_reset ##1 bus_core_reset |=> !irq)
		else $error("irq survives soft reset");
	a_gate_holds: assert property (
		(!link_clk_enable) [*6] ##0 link_core_reset |=> link_core_reset)
		else $error("link reset left with clock gated");
	a_soft_start: assert property (
		wr_rst && hwdata[0] |-> ##[1:2] bus_core_reset)
		else $error("soft reset not started");
	c_soft: cover property ($rose(bus_core_reset));
	c_irq: cover property ($rose(irq));
	c_gated: cover property (!link_clk_enable && link_core_reset);
endmodule // otg_props
bind usb_otg_reset_and_interrupts otg_props otg_props_inst (
	.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hwdata(hwdata), .link_clk_enable(link_clk_enable),
	.phy_stop(phy_stop), .bus_core_reset(bus_core_reset),
	.link_core_reset(link_core_reset), .irq(irq));
`default_nettype wire

// [bench/phy_rst_model.sv]
// link phy clock source and reset manager model
`default_nettype none
module phy_rst_model (
	input wire logic mclk,
	input wire logic phy_stop,
	input wire logic pins_ready,
	input wire logic sw_release,
	output logic link_clk,
	output logic rst
);
	timeunit 1ns;
	timeprecision 100ps;
	logic run = 1'b0;
	int edges = 0;
	initial link_clk = 1'b0;
	initial rst = 1'b1;
	// no clock until stop reaches the phy through the pin mux
	always @(posedge mclk) if (phy_stop && pins_ready) run <= 1'b1;
	always #62.5 if (run) link_clk = ~link_clk;
	always @(posedge link_clk or negedge sw_release)
		if (!sw_release) edges <= 0;
		else if (edges < 12) edges <= edges + 1;
	// release waits for software and twelve link cycles
	always @(posedge mclk) rst <= !(sw_release && edges == 12);
endmodule // phy_rst_model
`default_nettype wire

// [bench/testbench.sv]
// self-checking bench for the reset and interrupt block
`default_nettype none
`include "usb_otg_rst_irq_map.vh"
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk = 0, hsel = 0, hwrite = 0, host_mode = 1, sw_release = 0;
	logic ptx_half_empty = 0, rst, hready, hreadyout, link_clk, irq;
	logic link_clk_enable, phy_stop, bus_core_reset, link_core_reset, hresp;
	logic [1:0] htrans = 0;
	logic [7:0] haddr = 0;
	logic [31:0] hwdata = 0, hrdata, q;
	logic [26:0] events = 0;
	int errors = 0, num_checks = 0, cycles = 0;
	assign hready = hreadyout;
	initial forever #4 mclk = ~mclk;
	usb_otg_reset_and_interrupts usb_otg_reset_and_interrupts_inst (
		.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(`HSIZE_WORD), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.link_clk(link_clk),
		.host_mode(host_mode), .events(events), .irq(irq),
		.ptx_half_empty(ptx_half_empty), .link_clk_enable(link_clk_enable),
		.phy_stop(phy_stop), .bus_core_reset(bus_core_reset),
		.link_core_reset(link_core_reset));
	phy_rst_model phy_rst_model_inst (.mclk(mclk), .phy_stop(phy_stop),
		.pins_ready(1'b1), .sw_release(sw_release), .link_clk(link_clk),
		.rst(rst));
	task automatic give_verdict();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic [7:0] a, input logic w, logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge mclk);
		while (hready !== 1'b1) @(posedge mclk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		@(posedge mclk);
		while (hready !== 1'b1) @(posedge mclk);
		q = hrdata;
	endtask
	task automatic pulse(input logic [26:0] ev, input logic half);
		events <= ev;
		ptx_half_empty <= half;
		@(posedge mclk);
		events <= 27'h0;
		ptx_half_empty <= 1'b0;
		xfer(`OFF_INT_STATUS, 1'b0, 32'h0);
	endtask
	task automatic settle();
		repeat (900) if (rst || link_core_reset) @(posedge mclk);
	endtask
	task automatic reset_values();
		xfer(`OFF_CLK_CTRL, 1'b0, 32'h0);
		check(q, 32'h1);
		xfer(`OFF_INT_MASK, 1'b0, 32'h0);
		check(q, 32'h0);
		xfer(8'h20, 1'b0, 32'h0);
		check(q, 32'h0);
		check({hreadyout, hresp}, 32'h2);
		check({phy_stop, link_core_reset}, 32'h0);
	endtask
	task automatic events_sweep();
		logic [26:0] ok;
		xfer(`OFF_INT_MASK, 1'b1, 32'h7FFFFFF);
		for (int m = 0; m < 2; m++) begin
			host_mode <= (m == 0);
			ok = m ? ~`HOST_ONLY : ~`DEV_ONLY;
			for (int i = 0; i < `NUM_EV; i++) begin
				pulse(27'h1 << i, 1'b0);
				check(q, ok & (27'h1 << i));
				check(irq, ok[i]);
				xfer(`OFF_INT_STATUS, 1'b1, 32'h7FFFFFF);
			end
		end
	endtask
	task automatic ptx_and_mismatch();
		host_mode <= 1'b1;
		xfer(`OFF_HOST_CFG, 1'b1, 32'h1);
		pulse(27'h8, 1'b0);
		check(q, 32'h0);
		pulse(27'h0, 1'b1);
		check(q, 32'h8);
		xfer(`OFF_HOST_CFG, 1'b1, 32'h0);
		xfer(`OFF_INT_MASK, 1'b1, 32'h0);
		pulse(27'h20000, 1'b0);
		check(irq, 32'h0);
		xfer(`OFF_INT_STATUS, 1'b1, 32'h7FFFFFF);
		host_mode <= 1'b0;
		xfer(`OFF_HOST_CFG, 1'b0, 32'h0);
		repeat (2) @(posedge mclk);
		xfer(`OFF_INT_STATUS, 1'b0, 32'h0);
		check(q, 32'h40000);
		xfer(`OFF_INT_MASK, 1'b1, 32'h40000);
		// irq follows the new mask one edge later
		@(posedge mclk);
		xfer(`OFF_MODE, 1'b0, 32'h0);
		check(q, 32'h2);
	endtask
	task automatic soft_reset();
		xfer(`OFF_CLK_CTRL, 1'b1, 32'h1);
		xfer(`OFF_RST_CTRL, 1'b1, 32'h1);
		xfer(`OFF_RST_CTRL, 1'b0, 32'h0);
		check(q[0], 32'h1);
		repeat (300) if (q[0]) xfer(`OFF_RST_CTRL, 1'b0, 32'h0);
		check(q, 32'h0);
		xfer(`OFF_INT_STATUS, 1'b0, 32'h0);
		check(q, 32'h0);
		check(irq, 32'h0);
	endtask
	task automatic gate_and_hard_reset();
		xfer(`OFF_RST_CTRL, 1'b1, 32'h1);
		// gate once the link side is in reset, so it must stay there
		repeat (60) @(posedge mclk);
		xfer(`OFF_CLK_CTRL, 1'b1, 32'h0);
		repeat (200) @(posedge mclk);
		check(link_clk_enable, 32'h0);
		check(link_core_reset, 32'h1);
		xfer(`OFF_RST_CTRL, 1'b0, 32'h0);
		check(q, 32'h7);
		// a hard reset brings the gated core back, as enabling the clock again would
		sw_release <= 1'b0;
		repeat (3) @(posedge mclk);
		sw_release <= 1'b1;
		@(posedge mclk);
		settle();
		reset_values();
	endtask
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			give_verdict();
		end
	end
	initial begin
		repeat (20) @(posedge mclk);
		sw_release <= 1'b1;
		@(posedge mclk);
		settle();
		reset_values();
		events_sweep();
		ptx_and_mismatch();
		soft_reset();
		gate_and_hard_reset();
		give_verdict();
	end
endmodule // testbench
`default_nettype wire
